/* crb_pkg.sv */
// package: types and constants for the control register bus master
`default_nettype none

package crb_pkg;

  // ==========================================================
  // bus geometry and timing
  localparam int unsigned   ADDR_W   = 10;
  localparam int unsigned   DATA_W   = 32;
  localparam int unsigned   TMO_CYC  = 64;
  localparam int unsigned   CNT_W    = 7;
  localparam logic [6:0]    TMO_LAST = 7'(TMO_CYC - 1);
  localparam logic [6:0]    CNT_ONE  = 7'h01;
  localparam logic [6:0]    CNT_RST  = 7'h00;
  localparam logic [31:0]   ZERO32   = 32'h0000_0000;
  localparam logic [0:9]    ADDR_RST = 10'h000;

  // ==========================================================
  // link sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ADDR  = 5'h02,
    ST_REQ   = 5'h04,
    ST_DRAIN = 5'h08,
    ST_GAP   = 5'h10
  } crb_st_t;

  // ==========================================================
  // state records
  typedef struct packed {
    crb_st_t     st;
    logic        wr;
    logic        rq;
    logic        wq;
    logic [0:9]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        done;
  } crb_lnk_t;

  typedef struct packed {
    crb_lnk_t    lnk;
    logic        busy;
    logic        rdy;
    logic        tgo;
    logic        tab;
    logic        tmo;
    logic        dn1;
    logic        dn2;
    logic        dn3;
    logic [6:0]  cnt;
    logic        wr;
    logic [0:9]  addr;
    logic [31:0] wdata;
    logic        rsp_v;
    logic [31:0] rsp_d;
  } crb_core_t;

  typedef struct packed {
    crb_lnk_t    lnk;
    logic        rs1;
    logic        rs2;
    logic        g1;
    logic        g2;
    logic        g3;
    logic        a1;
    logic        a2;
    logic        a3;
    logic        abp;
    logic        tdn;
  } crb_bus_t;

  localparam crb_lnk_t  LNK_RST  = '{st: ST_IDLE, addr: ADDR_RST, wdata: ZERO32,
                                     rdata: ZERO32, rdat_q: ZERO32, default: '0};
  localparam crb_core_t CORE_RST = '{lnk: LNK_RST, cnt: CNT_RST, addr: ADDR_RST,
                                     wdata: ZERO32, rsp_d: ZERO32, default: '0};

endpackage

`default_nettype wire

/* crb_master.sv */
// module: control register bus master, core-clocked or bus-clocked
`timescale 1ns/10ps
`default_nettype none

module crb_master
  import crb_pkg::*;
#(
  parameter bit USE_BUS_CLK = 1'b0
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        dedicated_bus_clock,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [0:9]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  output wire logic        cmd_ready,
  output wire logic        rsp_valid,
  output wire logic [31:0] rsp_data,
  output wire logic        bus_read_request,
  output wire logic        bus_write_request,
  output wire logic [0:9]  bus_address,
  output wire logic [31:0] bus_write_data,
  input  wire logic        bus_acknowledge,
  input  wire logic [31:0] bus_read_data
);

  // ==========================================================
  // link sequencer, shared by both clocking variants
  // the acknowledge and read data are registered once; peripherals
  // sit on the link clock or on an edge-aligned relative of it
  function automatic crb_lnk_t lnk_step(
    input crb_lnk_t    s,
    input logic        go,
    input logic        wr,
    input logic [0:9]  addr,
    input logic [31:0] wdata,
    input logic        ack,
    input logic [31:0] rd,
    input logic        kill
  );
    crb_lnk_t n;
    n        = s;
    n.done   = 1'b0;
    n.ack_q  = ack;
    n.rdat_q = rd;
    unique case (s.st)
      ST_IDLE:
      begin
        if (go)
        begin
          n.st    = ST_ADDR;
          n.wr    = wr;
          n.addr  = addr;
          n.wdata = wr ? wdata : ZERO32;
          n.rdata = ZERO32;
        end
      end
      ST_ADDR:
      begin
        // address was put out one cycle ago
        n.st = ST_REQ;
        n.rq = ~s.wr;
        n.wq = s.wr;
      end
      ST_REQ:
      begin
        // acknowledge outranks a timeout landing in the same cycle
        if (s.ack_q || kill)
        begin
          n.rq   = 1'b0;
          n.wq   = 1'b0;
          n.done = 1'b1;
          n.st   = ST_DRAIN;
          if (s.ack_q && !s.wr)
          begin
            n.rdata = s.rdat_q;
          end
        end
      end
      ST_DRAIN:
      begin
        // a late acknowledge after a timeout is also waited out here
        if (!s.ack_q)
        begin
          n.st = ST_GAP;
        end
      end
      ST_GAP:
      begin
        n.st = ST_IDLE;
      end
      default:
      begin
        n = LNK_RST;
      end
    endcase
    return n;
  endfunction

  // ==========================================================
  // state
  crb_core_t c;
  crb_core_t next_c;
  crb_bus_t  b;
  crb_bus_t  next_b;

  logic      dn_e;
  logic      go_e;
  logic      ab_e;

  assign dn_e = c.dn2 ^ c.dn3;
  assign go_e = b.g2 ^ b.g3;
  assign ab_e = b.a2 ^ b.a3;

  // ==========================================================
  // core clock domain
  always_comb
  begin
    next_c       = c;
    next_c.rsp_v = 1'b0;
    next_c.dn1   = b.tdn;
    next_c.dn2   = c.dn1;
    next_c.dn3   = c.dn2;
    if (!USE_BUS_CLK)
    begin
      next_c.lnk = lnk_step(c.lnk, cmd_valid & c.rdy, cmd_write, cmd_addr,
                            cmd_wdata, bus_acknowledge, bus_read_data,
                            c.cnt == TMO_LAST);
      next_c.cnt   = (c.lnk.st == ST_REQ) ? c.cnt + CNT_ONE : CNT_RST;
      next_c.rdy   = next_c.lnk.st == ST_IDLE;
      next_c.rsp_v = next_c.lnk.done;
      next_c.rsp_d = next_c.lnk.rdata;
    end
    else
    begin
      if (c.busy)
      begin
        // timeout is counted in core cycles, the link is told by toggle
        if (!c.tmo)
        begin
          next_c.cnt = c.cnt + CNT_ONE;
        end
        if (dn_e)
        begin
          next_c.busy = 1'b0;
          if (!c.tmo)
          begin
            next_c.rsp_v = 1'b1;
            next_c.rsp_d = b.lnk.rdata;
          end
        end
        else if (!c.tmo && c.cnt == TMO_LAST)
        begin
          next_c.tmo   = 1'b1;
          next_c.tab   = ~c.tab;
          next_c.rsp_v = 1'b1;
          next_c.rsp_d = ZERO32;
        end
      end
      else if (cmd_valid && c.rdy)
      begin
        // command words stay put until the link reports done
        next_c.busy  = 1'b1;
        next_c.tgo   = ~c.tgo;
        next_c.wr    = cmd_write;
        next_c.addr  = cmd_addr;
        next_c.wdata = cmd_wdata;
        next_c.cnt   = CNT_RST;
        next_c.tmo   = 1'b0;
      end
      next_c.rdy = ~next_c.busy;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      c <= CORE_RST;
    end
    else
    begin
      c <= next_c;
    end
  end

  // ==========================================================
  // dedicated bus clock domain
  // reset reaches this side two bus edges late through its own sync
  always_comb
  begin
    next_b     = b;
    next_b.rs1 = srst;
    next_b.rs2 = b.rs1;
    next_b.g1  = c.tgo;
    next_b.g2  = b.g1;
    next_b.g3  = b.g2;
    next_b.a1  = c.tab;
    next_b.a2  = b.a1;
    next_b.a3  = b.a2;
    // a fresh start discards an abort meant for the previous access
    next_b.abp = go_e ? 1'b0 : (b.abp | ab_e);
    next_b.lnk = lnk_step(b.lnk, go_e, c.wr, c.addr, c.wdata,
                          bus_acknowledge, bus_read_data, b.abp);
    if (next_b.lnk.done)
    begin
      next_b.tdn = ~b.tdn;
    end
    if (b.rs2)
    begin
      next_b.lnk = LNK_RST;
      next_b.abp = 1'b0;
      next_b.tdn = 1'b0;
    end
  end

  always_ff @(posedge dedicated_bus_clock)
  begin
    b <= next_b;
  end

  // ==========================================================
  // outputs, each taken from a flop; bus side from the selected domain, command side always from the core
  assign cmd_ready         = c.rdy;
  assign rsp_valid         = c.rsp_v;
  assign rsp_data          = c.rsp_d;
  assign bus_read_request  = USE_BUS_CLK ? b.lnk.rq : c.lnk.rq;
  assign bus_write_request = USE_BUS_CLK ? b.lnk.wq : c.lnk.wq;
  assign bus_address       = USE_BUS_CLK ? b.lnk.addr : c.lnk.addr;
  assign bus_write_data    = USE_BUS_CLK ? b.lnk.wdata : c.lnk.wdata;

endmodule

`default_nettype wire

/* crb_master_sva.sv */
// checker: request timing and bus data of the bus master
`timescale 1ns/10ps
`default_nettype none
module crb_master_sva
  import crb_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic        bus_read_request,
  input wire logic        bus_write_request,
  input wire logic [0:9]  bus_address,
  input wire logic [31:0] bus_write_data,
  input wire logic        bus_acknowledge,
  input wire logic [31:0] bus_read_data
);
  // ====
  // properties
  logic       req;
  logic [7:0] hcnt;
  assign req = bus_read_request || bus_write_request;
  // counts sampled request-high cycles of the current access
  always_ff @(posedge clk)
  begin
    hcnt <= (srst || !req) ? 8'h00 : hcnt + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ack;  $rose(bus_acknowledge) && req;  endsequence
  sequence s_drop; req ##1 !req;                   endsequence
  AST_RST_REQ: assert property (disable iff (1'b0) srst |=> !req)
    else $error("request high in reset");
  AST_RST_WD: assert property (disable iff (1'b0) srst |=> bus_write_data == ZERO32)
    else $error("write data not zero in reset");
  AST_EXCL: assert property (!(bus_read_request && bus_write_request))
    else $error("read and write together");
  AST_DROP: assert property (s_ack |=> s_drop)
    else $error("request not dropped two cycles after ack");
  AST_HOLD: assert property ($fell(req) |-> $past(bus_acknowledge, 2) || hcnt == 8'h40)
    else $error("request withdrawn without cause");
  AST_TMO: assert property (req |-> hcnt < 8'h40)
    else $error("request longer than timeout");
  AST_LEAD: assert property ($rose(req) |-> $past(cmd_valid && cmd_ready, 2)
    && $stable(bus_address))
    else $error("request not one cycle after address");
  AST_STABLE: assert property (req && $past(req) |-> $stable(bus_address)
    && $stable(bus_write_data))
    else $error("address or data moved in access");
  AST_RDZERO: assert property (bus_read_request |-> bus_write_data == ZERO32)
    else $error("write data not zero on read");
  AST_GAP: assert property ($changed(bus_address) |-> !$past(bus_acknowledge))
    else $error("new address while ack high");
  AST_RDATA: assert property ($fell(bus_read_request) && $past(bus_acknowledge, 2)
    |-> rsp_valid && rsp_data == $past(bus_read_data, 2))
    else $error("read data not captured at ack");
endmodule
`default_nettype wire

/* crb_periph.sv */
// partner: one chain peripheral holding a single control register
`timescale 1ns/10ps
`default_nettype none
module crb_periph
  import crb_pkg::*;
#(
  parameter logic [0:9]  MY_ADDR = 10'h2C5,
  parameter logic [31:0] IMPL    = 32'h00FF_F0F0
)
(
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [0:9]  addr,
  input  wire logic [31:0] din,
  input  wire logic [3:0]  dly,
  input  wire logic        mute,
  output wire logic        ack,
  output wire logic [31:0] dout
);
  // ====
  // register, ack and chain
  logic [31:0] creg = 32'h0000_0000;
  logic [3:0]  wcnt = 4'h0;
  logic        hit;
  assign hit  = (rd || wr) && addr == MY_ADDR && !mute;
  // ack rides on the request, so it only falls once the request does
  assign ack  = hit && wcnt >= dly;
  assign dout = (hit && rd) ? (creg & IMPL) | (din & ~IMPL) : din;
  always_ff @(posedge clk)
  begin
    wcnt <= !hit ? 4'h0 : (ack ? wcnt : wcnt + 4'h1);
    if (hit && wr && wcnt == 4'h0)
      creg <= din & IMPL;
  end
endmodule
`default_nettype wire

/* testbench.sv */
// testbench: reset, writes and reads, slow acks, timeouts
`timescale 1ns/10ps
`default_nettype none
module testbench
  import crb_pkg::*;
;
  // ====
  // bench
  localparam logic [0:9]  MYA  = 10'h2C5;
  localparam logic [31:0] IMPL = 32'h00FF_F0F0;
  logic        clk = 1'b0, lclk = 1'b0, srst = 1'b1, cv = 1'b0, cw = 1'b0, mute = 1'b0;
  logic [0:9]  ca  = 10'h000;
  logic [31:0] cd  = 32'h0000_0000, r;
  logic [3:0]  dly = 4'h0;
  wire logic        crdy, rv, brq, bwq, back;
  wire logic [0:9]  badr;
  wire logic [31:0] rdat, bwd, brd;
  int error_cnt = 0, n_compared = 0, hi;
  initial forever #4 clk = ~clk;
  // only feeds the bus-clocked build; this one is core-clocked
  initial forever #3 lclk = ~lclk;
  crb_master uut (.clk(clk), .srst(srst), .dedicated_bus_clock(lclk), .cmd_valid(cv),
    .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd), .cmd_ready(crdy), .rsp_valid(rv),
    .rsp_data(rdat), .bus_read_request(brq), .bus_write_request(bwq), .bus_address(badr),
    .bus_write_data(bwd), .bus_acknowledge(back), .bus_read_data(brd));
  crb_periph #(.MY_ADDR(MYA), .IMPL(IMPL)) peer (.clk(clk), .rd(brq), .wr(bwq),
    .addr(badr), .din(bwd), .dly(dly), .mute(mute), .ack(back), .dout(brd));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one command; r is the response, hi the request-high cycles
  task automatic access(input logic w, input logic [0:9] a, input logic [31:0] d);
    int n;
    n = 0;
    hi = 0;
    @(posedge clk);
    {cv, cw, ca, cd} <= {1'b1, w, a, d};
    @(negedge clk);
    while (crdy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
    while (rv !== 1'b1 && n < 400)
    begin
      if (brq === 1'b1 || bwq === 1'b1)
      begin
        hi++;
        check("request kind", {30'h0, brq, bwq}, {30'h0, ~w, w});
        check("address", {22'h0, badr}, {22'h0, a});
        check("write data", bwd, w ? d : ZERO32);
      end
      @(negedge clk);
      n++;
    end
    r = rdat;
    check("rsp_valid", {31'h0, rv}, 32'h1);
  endtask
  task automatic t_reset();
    repeat (7) @(posedge clk);
    @(negedge clk);
    check("requests", {30'h0, brq, bwq}, 32'h0);
    check("reset write data", bwd, ZERO32);
    check("ready in reset", {31'h0, crdy}, 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("ready after reset", {31'h0, crdy}, 32'h1);
  endtask
  task automatic t_wr_rd(input logic [3:0] d, input logic [31:0] v);
    @(posedge clk);
    dly <= d;
    access(1'b1, MYA, v);
    check("write rsp", r, ZERO32);
    check("write req cycles", hi, 32'(d) + 32'h2);
    access(1'b0, MYA, 32'hFFFF_FFFF);
    check("read rsp", r, v & IMPL);
    check("read req cycles", hi, 32'(d) + 32'h2);
  endtask
  task automatic t_timeout();
    access(1'b1, MYA ^ 10'h001, 32'hFFFF_FFFF);
    check("stray write cycles", hi, TMO_CYC);
    @(posedge clk);
    mute <= 1'b1;
    access(1'b0, MYA, 32'h0000_0000);
    check("timeout rsp", r, ZERO32);
    check("timeout cycles", hi, TMO_CYC);
    @(posedge clk);
    mute <= 1'b0;
    access(1'b0, MYA, 32'h0000_0000);
    check("kept value", r, 32'h5A3C_60E8 & IMPL);
  endtask
  initial
  begin
    #20000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    t_reset();
    t_wr_rd(4'h0, 32'hA5C3_9F17);
    t_wr_rd(4'h3, 32'h5A3C_60E8);
    t_timeout();
    print_verdict();
  end
endmodule
bind crb_master crb_master_sva chk (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .bus_read_request(bus_read_request), .bus_write_request(bus_write_request),
  .bus_address(bus_address), .bus_write_data(bus_write_data),
  .bus_acknowledge(bus_acknowledge), .bus_read_data(bus_read_data));
`default_nettype wire
